// ### verilog/loop_sync_pkg.sv
// package: constants, register map and types of the loop measurement sequencer
package loop_sync_pkg;

    // clock and time base
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned TICK_US       = 100;
    localparam int unsigned TICK_CYC      = TICK_US * (CLK_HZ / 1_000_000);

    // measuring time per channel, held in ticks of 0.1 ms
    localparam int unsigned MEAS_US       = 1500;
    localparam logic [7:0]  MEAS_RST      = 8'(MEAS_US / TICK_US);

    // recommended cycle ceiling, only reported
    localparam int unsigned CYCLE_LIMIT_MS    = 8;
    localparam logic [11:0] CYCLE_LIMIT_TICKS = 12'(CYCLE_LIMIT_MS * 1000 / TICK_US);

    // indicator blink, 0.5 Hz
    localparam int unsigned BLINK_PERIOD_MS = 2000;
    localparam int unsigned BLINK_HALF_CYC  = (BLINK_PERIOD_MS / 2) * (CLK_HZ / 1000);

    // leader silence that ends synchronisation
    localparam int unsigned LOST_MS       = 50;
    localparam int unsigned LOST_CYC      = LOST_MS * (CLK_HZ / 1000);

    // leader restart announcement on the lines
    localparam int unsigned ANN_US        = 100;
    localparam logic [11:0] ANN_CYC       = 12'(ANN_US * (CLK_HZ / 1_000_000));
    localparam logic [11:0] ANN_DET       = 12'(ANN_US * (CLK_HZ / 1_000_000) / 2);

    // register byte addresses
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_MEAS     = 8'h04;
    localparam logic [7:0]  ADDR_STATUS   = 8'h08;
    localparam logic [7:0]  ADDR_CYCLE    = 8'h0C;
    localparam logic [7:0]  ADDR_RSTDIAG  = 8'h10;
    localparam logic [7:0]  ADDR_ALNDIAG  = 8'h14;

    // control bits
    localparam int unsigned CTRL_LEADER_BIT = 0;
    localparam int unsigned CTRL_CLEAR_BIT  = 1;

    // values after power-on reset
    localparam logic        LEADER_RST     = 1'b0;
    localparam logic [7:0]  RST_CAUSE_POR  = 8'h01;

    typedef enum logic [1:0] {
        ST_FREE     = 2'b00,
        ST_FOLLOW   = 2'b01,
        ST_LEAD     = 2'b10,
        ST_ANNOUNCE = 2'b11
    } sync_state_t;

    typedef struct packed {
        logic [7:0]  cause;
        logic [15:0] count;
    } reset_diag_t;

    typedef struct packed {
        logic        sync_cause;
        logic [15:0] count;
    } align_diag_t;

endpackage

// ### verilog/interval_timer.sv
// interval timer: restartable periodic one-cycle expiry pulse
`timescale 1ns/1ps
module interval_timer #(
    parameter int unsigned W = 12
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // control
    input  wire logic         restart,
    input  wire logic [W-1:0] period,
    output logic              expire
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         expire_d;

    always_comb begin
        cnt_d    = cnt_q - W'(1);
        expire_d = 1'b0;
        if (restart) begin
            cnt_d = period - W'(1);
        end else if (cnt_q == '0) begin
            cnt_d    = period - W'(1);
            expire_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            expire <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            expire <= expire_d;
        end
    end

endmodule

// ### verilog/loop_measure_sync.sv
// loop measurement sequencer with multi-detector channel synchronisation
//
// Behaviour
// - latest reset reason is kept as a bit-coded diagnostic value.
// - resets after power-on are counted; clear command zeroes count and cause.
// - unsynchronised, cycle time is the sum of the four channel measuring times.
// - synchronised, each slot lasts the longest time any detector needs for it.
// - synchronised detectors all measure the same channel number at once.
// - exactly one leader per group; leader role is off after power-on reset.
// - a follower locked to a leader refuses to switch its leader role on.
// - changing leader role neither resets nor interrupts measurement.
// - a follower seeing a leader appear starts sync with a full alignment.
// - a leader reset makes every follower restart sync with full alignment.
// - leader switched off makes followers leave sync with full alignment.
// - when locked, indicators blink at 0.5 Hz; leader blinks in antiphase.
// - default measuring time is 1.5 ms per channel, 6.0 ms per cycle.
// - sync-caused alignments are counted with cause recorded as synchronisation.
`timescale 1ns/1ps
module loop_measure_sync
    import loop_sync_pkg::*;
#(
    parameter int unsigned LOST_TIMEOUT_CYC = LOST_CYC,
    parameter int unsigned BLINK_HALF       = BLINK_HALF_CYC
) (
    // clock and power-on reset
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // synchronisation lines, open drain
    input  wire logic        SYNC1_I,
    output logic             SYNC1_O,
    output logic             SYNC1_OE_N,
    input  wire logic        SYNC2_I,
    output logic             SYNC2_O,
    output logic             SYNC2_OE_N,
    // reset events of the detector
    input  wire logic        RESET_EVT,
    input  wire logic [7:0]  RESET_CAUSE,
    // measurement front end
    output logic      [1:0]  CHANNEL,
    output logic             MEASURE,
    output logic             ALIGN_ALL,
    input  wire logic        ALIGN_BUSY,
    // front panel
    output logic             FUNCTION_INDICATOR
);

    sync_state_t      state_q, state_d;
    logic             leader_en_q, leader_en_d;
    logic [3:0][7:0]  meas_q, meas_d;
    logic [1:0]       ch_q, ch_d;
    logic [7:0]       slot_left_q, slot_left_d;
    logic             sync1_prev_q;
    logic [11:0]      ann_cnt_q, ann_cnt_d;
    logic [19:0]      lost_cnt_q, lost_cnt_d;
    logic [11:0]      cyc_acc_q, cyc_acc_d;
    logic [11:0]      cyc_time_q, cyc_time_d;
    reset_diag_t      rdiag_q, rdiag_d;
    align_diag_t      adiag_q, adiag_d;
    logic             align_d;
    logic             blink_run_q, blink_run_d;
    logic             blink_q, blink_d;
    logic             fi_d;
    logic             sync1_oe_n_d, sync2_oe_n_d;
    logic             measure_d;
    logic [31:0]      prdata_d;
    logic             pready_d, pslverr_d;

    logic             start_slot;
    logic             sync_fall;
    logic             tick;
    logic             blink_flip;
    logic             blink_start;
    logic             ready;
    logic             access;
    logic             wr_commit;
    logic             clear;
    logic [15:0]      rcount_base;
    logic [15:0]      acount_base;

    assign sync_fall = sync1_prev_q && !SYNC1_I;
    assign access    = PSEL && PENABLE;
    assign wr_commit = access && PREADY && PWRITE;
    assign clear     = wr_commit && (PADDR == ADDR_CTRL) && PWDATA[CTRL_CLEAR_BIT];

    // 0.1 ms tick, restarted per slot so each slot is a whole number of ticks
    interval_timer #(.W(12)) u_tick (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .restart (start_slot),
        .period  (12'(TICK_CYC)),
        .expire  (tick)
    );

    interval_timer #(.W(25)) u_blink (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .restart (blink_start),
        .period  (25'(BLINK_HALF)),
        .expire  (blink_flip)
    );

    // sequencer
    always_comb begin
        state_d     = state_q;
        ch_d        = ch_q;
        slot_left_d = slot_left_q;
        start_slot  = 1'b0;
        align_d     = 1'b0;
        lost_cnt_d  = 20'h00000;
        ann_cnt_d   = 12'h000;
        if (!SYNC2_I && SYNC1_I) begin
            ann_cnt_d = (ann_cnt_q == ANN_CYC) ? ann_cnt_q : ann_cnt_q + 12'h001;
        end
        if (tick && slot_left_q != 8'h00) begin
            slot_left_d = slot_left_q - 8'h01;
        end
        unique case (state_q)
            ST_FREE: begin
                if (!leader_en_q && sync_fall && !SYNC2_I) begin
                    state_d    = ST_FOLLOW;
                    align_d    = 1'b1;
                    start_slot = 1'b1;
                    ch_d       = 2'b00;
                end else begin
                    // measurement keeps running across the role change
                    if (leader_en_q) begin
                        state_d = ST_LEAD;
                    end
                    if (slot_left_q == 8'h00) begin
                        start_slot = 1'b1;
                        ch_d       = ch_q + 2'b01;
                    end
                end
            end
            ST_LEAD: begin
                if (!leader_en_q) begin
                    state_d = ST_FREE;
                end else if (RESET_EVT) begin
                    state_d     = ST_ANNOUNCE;
                    slot_left_d = 8'h00;
                end else if (slot_left_q == 8'h00 && SYNC1_I) begin
                    // wired line high: every detector has finished this slot
                    start_slot = 1'b1;
                    ch_d       = ch_q + 2'b01;
                end
            end
            ST_ANNOUNCE: begin
                slot_left_d = 8'h00;
                if (!leader_en_q) begin
                    state_d = ST_FREE;
                end else if (ann_cnt_q == ANN_CYC) begin
                    state_d    = ST_LEAD;
                    start_slot = 1'b1;
                    ch_d       = 2'b00;
                end
            end
            ST_FOLLOW: begin
                lost_cnt_d = lost_cnt_q + 20'h00001;
                if (sync_fall) begin
                    start_slot = 1'b1;
                    ch_d       = SYNC2_I ? ch_q + 2'b01 : 2'b00;
                    lost_cnt_d = 20'h00000;
                end else if (lost_cnt_q == 20'(LOST_TIMEOUT_CYC)) begin
                    state_d = ST_FREE;
                    align_d = 1'b1;
                end
                if (ann_cnt_q == ANN_DET && !SYNC2_I && SYNC1_I) begin
                    align_d = 1'b1;
                end
            end
        endcase
        if (start_slot) begin
            slot_left_d = (meas_q[ch_d] == 8'h00) ? 8'h01 : meas_q[ch_d];
        end
        measure_d    = slot_left_d != 8'h00;
        // each synchronised detector (leader or follower) holds line 1 low while it still measures the slot
        sync1_oe_n_d = !((state_d == ST_FOLLOW || state_d == ST_LEAD) && measure_d);
        sync2_oe_n_d = !(state_d == ST_ANNOUNCE || (state_d == ST_LEAD && ch_d == 2'b00));

        cyc_acc_d  = tick ? cyc_acc_q + 12'h001 : cyc_acc_q;
        cyc_time_d = cyc_time_q;
        if (start_slot && ch_d == 2'b00) begin
            cyc_time_d = cyc_acc_q;
            cyc_acc_d  = 12'h000;
        end
    end

    // diagnostics; an event in the clear cycle survives the clear
    always_comb begin
        rdiag_d     = rdiag_q;
        adiag_d     = adiag_q;
        rcount_base = clear ? 16'h0000 : rdiag_q.count;
        acount_base = clear ? 16'h0000 : adiag_q.count;
        if (clear) begin
            rdiag_d = '{cause: 8'h00, count: 16'h0000};
            adiag_d = '{sync_cause: 1'b0, count: 16'h0000};
        end
        if (RESET_EVT) begin
            rdiag_d.cause = RESET_CAUSE;
            rdiag_d.count = rcount_base + 16'h0001;
        end
        if (align_d) begin
            adiag_d.sync_cause = 1'b1;
            adiag_d.count      = acount_base + 16'h0001;
        end
    end

    // indicator; phase starts at the first channel-0 slot after lock
    always_comb begin
        ready       = (state_q == ST_FOLLOW || state_q == ST_LEAD) && !ALIGN_BUSY;
        blink_start = ready && !blink_run_q && start_slot && ch_d == 2'b00;
        blink_run_d = ready && (blink_run_q || blink_start);
        blink_d     = blink_start ? 1'b0 : (blink_flip ? !blink_q : blink_q);
        // steady on while not locked
        fi_d        = blink_run_d ? (blink_d ^ (state_q == ST_LEAD)) : 1'b1;
    end

    // apb: one wait state, write lands on the pready edge
    always_comb begin
        leader_en_d = leader_en_q;
        meas_d      = meas_q;
        pready_d    = access && !PREADY;
        prdata_d    = 32'h0000_0000;
        pslverr_d   = 1'b0;
        if (access && !PREADY) begin
            case (PADDR)
                ADDR_CTRL:    prdata_d = {31'h0000_0000, leader_en_q};
                ADDR_MEAS:    prdata_d = meas_q;
                ADDR_STATUS:  prdata_d = {24'h00_0000, 1'b0,
                                          cyc_time_q > CYCLE_LIMIT_TICKS,
                                          blink_run_q, state_q == ST_FOLLOW,
                                          ch_q, state_q};
                ADDR_CYCLE:   prdata_d = {20'h0_0000, cyc_time_q};
                ADDR_RSTDIAG: prdata_d = {8'h00, rdiag_q};
                ADDR_ALNDIAG: prdata_d = {15'h0000, adiag_q};
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
        if (wr_commit && PADDR == ADDR_CTRL) begin
            // a locked follower may drop but never take the leader role
            if (!(state_q == ST_FOLLOW && PWDATA[CTRL_LEADER_BIT])) begin
                leader_en_d = PWDATA[CTRL_LEADER_BIT];
            end
        end
        if (wr_commit && PADDR == ADDR_MEAS) begin
            meas_d = PWDATA;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_q      <= ST_FREE;
            leader_en_q  <= LEADER_RST;
            meas_q       <= {4{MEAS_RST}};
            ch_q         <= 2'b11;
            slot_left_q  <= 8'h00;
            sync1_prev_q <= 1'b1;
            ann_cnt_q    <= 12'h000;
            lost_cnt_q   <= 20'h00000;
            cyc_acc_q    <= 12'h000;
            cyc_time_q   <= 12'h000;
            rdiag_q      <= '{cause: RST_CAUSE_POR, count: 16'h0000};
            adiag_q      <= '{sync_cause: 1'b0, count: 16'h0000};
            blink_run_q  <= 1'b0;
            blink_q      <= 1'b0;
            PRDATA       <= 32'h0000_0000;
            PREADY       <= 1'b0;
            PSLVERR      <= 1'b0;
            SYNC1_O      <= 1'b0;
            SYNC1_OE_N   <= 1'b1;
            SYNC2_O      <= 1'b0;
            SYNC2_OE_N   <= 1'b1;
            CHANNEL      <= 2'b11;
            MEASURE      <= 1'b0;
            ALIGN_ALL    <= 1'b0;
            FUNCTION_INDICATOR <= 1'b1;
        end else begin
            state_q      <= state_d;
            leader_en_q  <= leader_en_d;
            meas_q       <= meas_d;
            ch_q         <= ch_d;
            slot_left_q  <= slot_left_d;
            sync1_prev_q <= SYNC1_I;
            ann_cnt_q    <= ann_cnt_d;
            lost_cnt_q   <= lost_cnt_d;
            cyc_acc_q    <= cyc_acc_d;
            cyc_time_q   <= cyc_time_d;
            rdiag_q      <= rdiag_d;
            adiag_q      <= adiag_d;
            blink_run_q  <= blink_run_d;
            blink_q      <= blink_d;
            PRDATA       <= prdata_d;
            PREADY       <= pready_d;
            PSLVERR      <= pslverr_d;
            SYNC1_O      <= 1'b0;
            SYNC1_OE_N   <= sync1_oe_n_d;
            SYNC2_O      <= 1'b0;
            SYNC2_OE_N   <= sync2_oe_n_d;
            CHANNEL      <= ch_d;
            MEASURE      <= measure_d;
            ALIGN_ALL    <= align_d;
            FUNCTION_INDICATOR <= fi_d;
        end
    end

endmodule

// ### verification/loop_measure_sync_asserts.sv
// port checks of the loop measurement sequencer
`timescale 1ns/1ps
module loop_measure_sync_asserts
    import loop_sync_pkg::*;
#(
    parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
) (
    // clock and reset
    input wire logic        CLOCK,
    input wire logic        RST_N,
    // apb answer
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // lines and front end
    input wire logic        SYNC1_I,
    input wire logic        SYNC2_I,
    input wire logic        SYNC1_OE_N,
    input wire logic        SYNC2_OE_N,
    input wire logic        SYNC1_O,
    input wire logic        SYNC2_O,
    input wire logic        MEASURE,
    input wire logic [1:0]  CHANNEL,
    input wire logic        ALIGN_ALL,
    input wire logic        FUNCTION_INDICATOR
);
    logic [31:0] dark_q;
    logic [31:0] dark_d;

    // a stuck dark indicator shows up as an over-long dark phase
    always_comb dark_d = FUNCTION_INDICATOR ? 32'h0 : dark_q + 32'h1;
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) dark_q <= 32'h0;
        else dark_q <= dark_d;
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence s_answer;
        PREADY ##1 !PREADY;
    endsequence
    sequence s_joined;
        !SYNC1_OE_N && CHANNEL == 2'h0;
    endsequence

    a_apb_one_wait: assert property (PSEL && PENABLE && !PREADY |=> s_answer)
        else $error("apb answer not after one wait state");
    a_err_no_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error answer carries data");
    a_align_one_cycle: assert property (ALIGN_ALL |=> !ALIGN_ALL)
        else $error("alignment request longer than one cycle");
    a_blink_half_period: assert property (dark_q <= BLINK_HALF + 1)
        else $error("indicator dark longer than half period");
    a_marker_first_slot: assert property (
        !SYNC2_OE_N && !SYNC1_OE_N |-> CHANNEL == 2'h0)
        else $error("marker line driven outside first channel");
    a_join_on_fall: assert property (
        $fell(SYNC1_I) && !SYNC2_I && SYNC2_OE_N |-> ##[1:2] s_joined)
        else $error("no first slot after marked line fall");
    a_slot_on_line: assert property (
        $changed(CHANNEL) && !SYNC1_OE_N |-> $past(SYNC1_I) || $past(SYNC1_I, 2))
        else $error("slot started while line busy");
    a_reset_follower: assert property (
        $rose(RST_N) |-> SYNC1_OE_N && SYNC2_OE_N && CHANNEL == 2'h3)
        else $error("lines driven after reset");
    a_busy_needs_measure: assert property (!SYNC1_OE_N |-> MEASURE)
        else $error("busy line held without measuring");
    a_open_drain_low: assert property (!SYNC1_O && !SYNC2_O)
        else $error("sync line data not low");
endmodule

bind loop_measure_sync loop_measure_sync_asserts #(.BLINK_HALF(BLINK_HALF)) u_asserts (
    .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SYNC1_I(SYNC1_I), .SYNC2_I(SYNC2_I),
    .SYNC1_OE_N(SYNC1_OE_N), .SYNC2_OE_N(SYNC2_OE_N), .SYNC1_O(SYNC1_O),
    .SYNC2_O(SYNC2_O), .MEASURE(MEASURE), .CHANNEL(CHANNEL),
    .ALIGN_ALL(ALIGN_ALL), .FUNCTION_INDICATOR(FUNCTION_INDICATOR)
);

// ### verification/sync_leader_model.sv
// peer detector acting as timing leader on the shared sync lines
`timescale 1ns/1ps
module sync_leader_model
    import loop_sync_pkg::*;
(
    // clock
    input  wire logic        clk,
    // bench control
    input  wire logic        lead,
    input  wire logic        restart,
    input  wire logic [31:0] times,
    // wired line and own pull-downs
    input  wire logic        line1,
    output logic             pull1_n,
    output logic             pull2_n,
    output logic      [1:0]  ch
);
    int req_n = 0;
    int ack_n = 0;
    int n;

    // restart waits for the running slot to end
    always @(posedge clk) begin
        if (restart) req_n <= req_n + 1;
    end
    // one process owns the pulls and the channel
    initial begin
        pull1_n = 1'b1;
        pull2_n = 1'b1;
        ch = 2'h0;
        forever begin
            @(posedge clk);
            if (req_n != ack_n && lead) begin
                ack_n <= req_n;
                ch <= 2'h0;
                pull1_n <= 1'b1;
                pull2_n <= 1'b0;
                repeat (int'(ANN_CYC)) @(posedge clk);
            end else if (lead) begin
                pull1_n <= 1'b0;
                pull2_n <= (ch != 2'h0);
                repeat (int'(times[8*ch +: 8]) * TICK_CYC) @(posedge clk);
                pull1_n <= 1'b1;
                // the slot ends only once every detector lets go
                for (n = 0; n < 50000 && !line1; n++) @(posedge clk);
                ch <= ch + 2'h1;
            end else begin
                pull1_n <= 1'b1;
                pull2_n <= 1'b1;
            end
        end
    end
endmodule

// ### verification/loop_measure_sync_bench.sv
// self-checking bench of the loop measurement sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module loop_measure_sync_bench
    import loop_sync_pkg::*;
;
    logic        CLOCK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00, RESET_CAUSE = 8'h00, cause;
    logic [31:0] PWDATA = 32'h0, peer_times = 32'h0, PRDATA, rv;
    logic        RESET_EVT = 1'b0, ALIGN_BUSY = 1'b0, lead = 1'b0, restart = 1'b0;
    logic        PREADY, PSLVERR, ev, SYNC1_O, SYNC1_OE_N, SYNC2_O, SYNC2_OE_N, p1_n, p2_n;
    logic        MEASURE, ALIGN_ALL, FUNCTION_INDICATOR;
    logic [1:0]  CHANNEL, peer_ch;
    wire logic   SYNC1_I = (SYNC1_OE_N | SYNC1_O) & p1_n;
    wire logic   SYNC2_I = (SYNC2_OE_N | SYNC2_O) & p2_n;
    int          failures = 0, cmp_count = 0, aln_seen = 0, busy_n = 0, s, i, t[4], p[4];

    always #25 CLOCK = ~CLOCK;

    loop_measure_sync #(.LOST_TIMEOUT_CYC(9000), .BLINK_HALF(200)) u_loop_measure_sync (
        .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .SYNC1_I(SYNC1_I), .SYNC1_O(SYNC1_O), .SYNC1_OE_N(SYNC1_OE_N), .SYNC2_I(SYNC2_I),
        .SYNC2_O(SYNC2_O), .SYNC2_OE_N(SYNC2_OE_N), .RESET_EVT(RESET_EVT),
        .RESET_CAUSE(RESET_CAUSE), .CHANNEL(CHANNEL), .MEASURE(MEASURE),
        .ALIGN_ALL(ALIGN_ALL), .ALIGN_BUSY(ALIGN_BUSY), .FUNCTION_INDICATOR(FUNCTION_INDICATOR)
    );
    sync_leader_model u_sync_leader_model (
        .clk(CLOCK), .lead(lead), .restart(restart), .times(peer_times),
        .line1(SYNC1_I), .pull1_n(p1_n), .pull2_n(p2_n), .ch(peer_ch)
    );

    // front end stays busy for a while after each alignment request
    always @(posedge CLOCK) begin
        if (ALIGN_ALL === 1'b1) aln_seen <= aln_seen + 1;
        busy_n <= (ALIGN_ALL === 1'b1) ? 20 : (busy_n > 0 ? busy_n - 1 : 0);
        ALIGN_BUSY <= busy_n > 1 || ALIGN_ALL === 1'b1;
    end

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        rv = PRDATA;
        ev = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1) begin failures++; test_done(); end
        @(posedge CLOCK);
    endtask

    task automatic check_reg(input string nm, input logic [7:0] a,
                             input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rv & m)
    endtask

    // k = 0 waits for an alignment request, else for channel k-1
    task automatic hold(input int k, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while ((k == 0 ? ALIGN_ALL !== 1'b1 : CHANNEL !== 2'(k - 1)) && n < lim);
        if (n >= lim) begin failures++; test_done(); end
    endtask

    task automatic evt(input logic [7:0] c);
        RESET_EVT <= 1'b1;
        RESET_CAUSE <= c;
        @(posedge CLOCK);
        RESET_EVT <= 1'b0;
        @(posedge CLOCK);
    endtask

    initial begin
        void'($urandom(82692));
        repeat (6) @(posedge CLOCK);
        RST_N <= 1'b1;
        @(posedge CLOCK);
        check_reg("ctrl", ADDR_CTRL, 32'h0);
        check_reg("meas", ADDR_MEAS, 32'h0F0F0F0F);
        check_reg("rstdiag", ADDR_RSTDIAG, {8'h00, RST_CAUSE_POR, 16'h0000});
        apb(1'b0, 8'h18, 32'h0);
        `CHK("slverr", 1'b1, ev)
        // short slots keep the run small and every cycle under 8 ms
        for (i = 0; i < 4; i++) begin
            t[i] = 1 + $urandom % 2;
            p[i] = 1 + $urandom % 2;
            peer_times[8*i +: 8] <= 8'(p[i]);
        end
        apb(1'b1, ADDR_MEAS, {8'(t[3]), 8'(t[2]), 8'(t[1]), 8'(t[0])});
        hold(4, 40000);
        hold(1, 20000);
        hold(4, 20000);
        hold(1, 20000);
        check_reg("cycle", ADDR_CYCLE, 32'(t[0] + t[1] + t[2] + t[3]));
        check_reg("limit", ADDR_STATUS, 32'h0, 32'h40);
        cause = 8'($urandom);
        evt(~cause);
        evt(cause);
        check_reg("rstdiag", ADDR_RSTDIAG, {8'h00, cause, 16'h0002});
        apb(1'b1, ADDR_CTRL, 32'h2);
        check_reg("rstdiag", ADDR_RSTDIAG, 32'h0);
        lead <= 1'b1;
        hold(0, 40000);
        repeat (100) @(posedge CLOCK);
        `CHK("channel", peer_ch, CHANNEL)
        check_reg("alndiag", ADDR_ALNDIAG, 32'h00010001);
        apb(1'b1, ADDR_CTRL, 32'h1);
        check_reg("ctrl", ADDR_CTRL, 32'h0);
        check_reg("state", ADDR_STATUS, 32'h1, 32'h3);
        s = 0;
        for (i = 0; i < 4; i++) s += (t[i] > p[i]) ? t[i] : p[i];
        hold(4, 20000);
        hold(1, 20000);
        check_reg("cycle", ADDR_CYCLE, 32'(s));
        check_reg("blink", ADDR_STATUS, 32'h20, 32'h20);
        restart <= 1'b1;
        @(posedge CLOCK);
        restart <= 1'b0;
        hold(0, 20000);
        check_reg("alndiag", ADDR_ALNDIAG, 32'h00010002);
        lead <= 1'b0;
        hold(0, 20000);
        check_reg("state", ADDR_STATUS, 32'h0, 32'h3);
        check_reg("alndiag", ADDR_ALNDIAG, 32'h00010003);
        apb(1'b1, ADDR_CTRL, 32'h1);
        check_reg("ctrl", ADDR_CTRL, 32'h1);
        check_reg("state", ADDR_STATUS, 32'h2, 32'h3);
        hold(2, 20000);
        `CHK("aligns", 3, aln_seen)
        evt(8'h11);
        check_reg("state", ADDR_STATUS, 32'h3, 32'h3);
        test_done();
    end
endmodule
